// file: hdl/cdoa_alu.sv
// Purpose: Double-operand arithmetic and logic datapath with register file
// Assumes: Sequencer writes operands, then a command; result next cycle
// Notes:   Byte forms run on operands shifted into the high byte
//
// Chosen here: the register addresses and strobed register access.
`default_nettype none

// Overview of operation
// RULE1 - Swap bytes; low-byte flags, clear V C
// RULE2 - Source latched; destination stepping never alters it
// RULE3 - Move copies source; N Z set, V clear
// RULE4 - Byte move to register sign-extends bit 7
// RULE5 - Add writes sum; carry from top bit
// RULE6 - Add overflow on same signs, flipped result
// RULE7 - Subtract writes difference; carry on borrow
// RULE8 - Subtract overflow: signs differ, result matches source
// RULE9 - Compare sets flags only, no operand write
// RULE10 - Compare overflow: differ, result sign of second
// RULE11 - Multiply: high half to n, low to n|1
// RULE12 - Multiply carry when product exceeds 16 bits
// RULE13 - Odd register multiply stores low half only
// RULE14 - Divide: quotient to n, remainder to n|1
// RULE15 - Zero divisor sets V C, no writes
// RULE16 - Quotient out of range sets overflow
// RULE17 - Exclusive-or named register into destination
// RULE18 - Bit set ORs source into destination
// RULE19 - Bit clear ANDs inverted source in
// RULE20 - Multiply into stack pointer or PC undefined
// RULE21 - Byte forms use bit 7, low byte
module cdoa_alu (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Register port
   input  wire cdoa_pkg::cdoa_bus_req_t bus_req,
   output logic [cdoa_pkg::DW-1:0]     rdata_q,
   // Results toward the sequencer
   output logic [cdoa_pkg::DW-1:0]     result_q,
   output logic                        dst_wr_q,
   output logic                        done_q,
   output cdoa_pkg::cdoa_cc_t          cc_q
);
   import cdoa_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0]  gpr_q [8];     // General registers
   logic [15:0]  src_q;         // Latched source operand
   logic [15:0]  dst_q;         // Latched destination operand
   logic [15:0]  step_addr_q;   // Address from last step
   cdoa_ctrl_t   cmd;           // Decoded command
   logic         exec;          // Command write this cycle
   logic         step_hit;      // Step write this cycle
   logic [2:0]   rn1;           // Register n OR 1
   logic [15:0]  rn_val;        // Named register value
   logic [15:0]  rn1_val;       // Partner register value
   logic [15:0]  sa;            // Aligned source
   logic [15:0]  da;            // Aligned destination
   logic [16:0]  sum;           // Aligned sum with carry
   logic [16:0]  dif;           // Aligned difference with borrow
   logic [15:0]  mnd;           // Minuend
   logic [15:0]  sbt;           // Subtrahend
   logic [31:0]  prod;          // Signed product
   logic [31:0]  dvd;           // Dividend
   logic [31:0]  dvs;           // Divisor, never zero
   logic [31:0]  quo;           // Quotient
   logic [31:0]  rem;           // Remainder
   logic [15:0]  ral;           // Aligned result
   logic [15:0]  res_d;         // Result word
   cdoa_cc_t     cc_d;          // Next condition codes
   logic         dst_wr_d;      // Result goes to destination
   logic         hi_we;         // Write register n
   logic         lo_we;         // Write register n|1
   logic [15:0]  hi_val;        // Value for register n
   logic [15:0]  lo_val;        // Value for register n|1
   logic [2:0]   st_idx;        // Stepped register
   logic [15:0]  st_amt;        // Step amount
   logic [15:0]  st_new;        // Stepped value

   assign cmd      = cdoa_ctrl_t'(bus_req.wdata[8:0]);
   assign exec     = bus_req.wr && (bus_req.addr == ADR_CTRL);
   assign step_hit = bus_req.wr && (bus_req.addr == ADR_STEP);
   assign rn1      = cmd.rn | 3'h1;
   assign rn_val   = gpr_q[cmd.rn];
   assign rn1_val  = gpr_q[rn1];

   ////////////////////////////////////////////////////////////////////////
   // Operand latches
   // Source only changes on its own write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_q <= WORD_RST;
      end else if (bus_req.wr && bus_req.addr == ADR_SRC) begin
         src_q <= bus_req.wdata;  // see RULE2
      end
   end

   // Destination latch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dst_q <= WORD_RST;
      end else if (bus_req.wr && bus_req.addr == ADR_DST) begin
         dst_q <= bus_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Auto-increment and auto-decrement
   // Stack pointer and PC always step by a word
   always_comb begin
      st_idx = bus_req.wdata[2:0];
      st_amt = (bus_req.wdata[STEP_BYTE_BIT] && st_idx < SP_IDX) ? BYTE_STEP
                                                                  : WORD_STEP;
      st_new = bus_req.wdata[STEP_SUB_BIT] ? gpr_q[st_idx] - st_amt
                                           : gpr_q[st_idx] + st_amt;
   end

   // Effective address: old value on increment, new on decrement
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         step_addr_q <= WORD_RST;
      end else if (step_hit) begin
         step_addr_q <= bus_req.wdata[STEP_SUB_BIT] ? st_new : gpr_q[st_idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Datapath
   always_comb begin
      // Byte forms work in the high byte so flags come out right
      sa   = cmd.byte_op ? {src_q[7:0], 8'h00} : src_q;  // see RULE21
      da   = cmd.byte_op ? {dst_q[7:0], 8'h00} : dst_q;
      sum  = {1'b0, da} + {1'b0, sa};
      // Compare subtracts second source from first
      mnd  = (cmd.op == op_compare) ? sa : da;
      sbt  = (cmd.op == op_compare) ? da : sa;
      dif  = {1'b0, mnd} - {1'b0, sbt};
      prod = 32'($signed(rn_val) * $signed(src_q));
      dvd  = {rn_val, rn1_val};
      dvs  = (src_q == WORD_RST) ? 32'h0000_0001 : {{16{src_q[15]}}, src_q};
      quo  = 32'($signed(dvd) / $signed(dvs));
      rem  = 32'($signed(dvd) % $signed(dvs));
      ral      = WORD_RST;
      res_d    = result_q;
      cc_d     = cc_q;
      dst_wr_d = 1'b0;
      hi_we    = 1'b0;
      lo_we    = 1'b0;
      hi_val   = prod[31:16];
      lo_val   = prod[15:0];
      case (cmd.op)
         op_move: begin
            ral    = sa;                        // see RULE3
            cc_d.v = 1'b0;
         end
         op_or_set: begin
            ral    = da | sa;                   // see RULE18
            cc_d.v = 1'b0;
         end
         op_and_clear: begin
            ral    = da & ~sa;                  // see RULE19
            cc_d.v = 1'b0;
         end
         op_add: begin
            ral    = sum[15:0];                 // see RULE5
            cc_d.c = sum[16];
            cc_d.v = (da[15] == sa[15]) && (sum[15] != da[15]);  // see RULE6
         end
         op_sub, op_compare: begin
            ral    = dif[15:0];                 // see RULE7
            cc_d.c = dif[16];                   // see RULE9
            // Same form serves both: second operand is sbt
            cc_d.v = (mnd[15] != sbt[15]) && (dif[15] == sbt[15]);  // see RULE8 RULE10
         end
         op_xor: begin
            ral    = rn_val ^ dst_q;            // see RULE17
            cc_d.v = 1'b0;
         end
         op_byte_swap: begin
            ral    = {dst_q[7:0], dst_q[15:8]}; // see RULE1
            cc_d.v = 1'b0;
            cc_d.c = 1'b0;
         end
         default: ;
      endcase
      // Word-style result and flags for the destination ops
      case (cmd.op)
         op_move, op_or_set, op_and_clear, op_add, op_sub, op_compare: begin
            cc_d.n   = ral[15];
            cc_d.z   = (ral == WORD_RST);
            dst_wr_d = (cmd.op != op_compare);  // see RULE9
            if (!cmd.byte_op) begin
               res_d = ral;
            end else if (cmd.op == op_move && cmd.dreg) begin
               res_d = {{8{ral[15]}}, ral[15:8]};  // see RULE4
            end else begin
               res_d = {dst_q[15:8], ral[15:8]};   // see RULE21
            end
         end
         op_xor: begin
            cc_d.n   = ral[15];
            cc_d.z   = (ral == WORD_RST);
            dst_wr_d = 1'b1;
            res_d    = ral;
         end
         op_byte_swap: begin
            cc_d.n   = ral[7];                  // see RULE1
            cc_d.z   = (ral[7:0] == 8'h00);
            dst_wr_d = 1'b1;
            res_d    = ral;
         end
         op_multiply: begin
            // Stack pointer or PC as target is left undefined; see RULE20
            cc_d.n = prod[31];                  // see RULE11
            cc_d.z = (prod == 32'h0000_0000);
            cc_d.v = 1'b0;
            cc_d.c = (prod[31:15] != {17{prod[31]}});  // see RULE12
            hi_we  = 1'b1;
            lo_we  = !cmd.rn[0];
            if (cmd.rn[0]) begin
               hi_val = prod[15:0];             // see RULE13
            end
            res_d = prod[15:0];
         end
         op_divide: begin
            if (src_q == WORD_RST) begin
               cc_d.v = 1'b1;                   // see RULE15
               cc_d.c = 1'b1;
            end else begin
               cc_d.v = (quo[31:15] != {17{quo[31]}});  // see RULE16
               cc_d.c = 1'b0;
               cc_d.n = quo[15];
               cc_d.z = (quo[15:0] == WORD_RST);
               hi_val = quo[15:0];              // see RULE14
               lo_val = rem[15:0];
               hi_we  = !cc_d.v;
               lo_we  = !cc_d.v;
               res_d  = quo[15:0];
            end
         end
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file, one entry per loop pass
   // Low half, checked first, wins when n and n|1 coincide
   for (genvar i = 0; i < 8; i++) begin : g_gpr
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            gpr_q[i] <= WORD_RST;
         end else if (bus_req.wr && bus_req.addr == ADR_GPR0 + 4'(i)) begin
            gpr_q[i] <= bus_req.wdata;
         end else if (step_hit && st_idx == 3'(i)) begin
            gpr_q[i] <= st_new;  // see RULE2
         end else if (exec && lo_we && rn1 == 3'(i)) begin
            gpr_q[i] <= lo_val;  // see RULE11
         end else if (exec && hi_we && cmd.rn == 3'(i)) begin
            gpr_q[i] <= hi_val;  // see RULE14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result and condition codes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_q <= WORD_RST;
         dst_wr_q <= 1'b0;
      end else begin
         result_q <= exec ? res_d : result_q;
         dst_wr_q <= exec && dst_wr_d;  // One-cycle write request
      end
   end

   // Condition codes, also loaded by the sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cc_q <= cdoa_cc_t'(CC_RST);
      end else if (exec) begin
         cc_q <= cc_d;
      end else if (bus_req.wr && bus_req.addr == ADR_CC) begin
         cc_q <= cdoa_cc_t'(bus_req.wdata[3:0]);
      end
   end

   // Done level, set by a command, cleared by a new source operand write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else if (exec) begin
         done_q <= 1'b1;
      end else if (bus_req.wr && bus_req.addr == ADR_SRC) begin
         done_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n || !bus_req.rd) begin
         rdata_q <= WORD_RST;
      end else if (bus_req.addr[3]) begin
         rdata_q <= gpr_q[bus_req.addr[2:0]];
      end else begin
         case (bus_req.addr)
            ADR_SRC:  rdata_q <= src_q;
            ADR_DST:  rdata_q <= dst_q;
            ADR_STEP: rdata_q <= step_addr_q;
            ADR_CC:   rdata_q <= {12'h000, cc_q};
            ADR_RES:  rdata_q <= result_q;
            ADR_STAT: rdata_q <= {14'h0000, dst_wr_q, done_q};
            default:  rdata_q <= WORD_RST;  // Unmapped reads zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_SWAP_FLAGS: assert property ( // see RULE1
      exec && cmd.op == op_byte_swap |=> !cc_q.v && !cc_q.c
         && result_q == {$past(dst_q[7:0]), $past(dst_q[15:8])})
      else $error("byte swap result or flags wrong");
   AST_SRC_HOLD: assert property ( // see RULE2
      bus_req.wr && bus_req.addr != ADR_SRC |=> $stable(src_q))
      else $error("source changed without its own write");
   AST_MOVE_KEEP_C: assert property ( // see RULE3
      exec && cmd.op == op_move |=> cc_q.c == $past(cc_q.c) && !cc_q.v)
      else $error("move altered carry or left overflow set");
   AST_MOVE_BYTE_OP_SEXT: assert property ( // see RULE4
      exec && cmd.op == op_move && cmd.byte_op && cmd.dreg
         |=> result_q == {{8{$past(src_q[7])}}, $past(src_q[7:0])})
      else $error("byte move to register not sign extended");
   AST_ADD_SUM: assert property ( // see RULE5
      exec && cmd.op == op_add && !cmd.byte_op
         |=> result_q == 16'($past(dst_q) + $past(src_q)) && dst_wr_q)
      else $error("add result wrong");
   AST_SUB_BORROW: assert property ( // see RULE7
      exec && cmd.op == op_sub && !cmd.byte_op
         |=> cc_q.c == ($past(dst_q) < $past(src_q)))
      else $error("subtract borrow wrong");
   AST_CMP_NOWRITE: assert property ( // see RULE9
      exec && cmd.op == op_compare |=> !dst_wr_q ##1 !dst_wr_q || $past(exec))
      else $error("compare requested a write");
   AST_MUL_HALVES: assert property ( // see RULE12
      exec && cmd.op == op_multiply && !cmd.rn[0] && !bus_req.rd
         |=> !cc_q.v && cc_q.c == (result_q[15] ? ~&gpr_q[$past(cmd.rn)]
                                                : |gpr_q[$past(cmd.rn)]))
      else $error("multiply carry disagrees with high half");
   AST_DIV_ZERO: assert property ( // see RULE15
      exec && cmd.op == op_divide && src_q == WORD_RST
         |=> cc_q.v && cc_q.c && gpr_q[$past(cmd.rn)] == $past(rn_val))
      else $error("zero divisor not handled");
   AST_XOR_RES: assert property ( // see RULE17
      exec && cmd.op == op_xor |=> result_q == ($past(rn_val) ^ $past(dst_q)))
      else $error("exclusive-or result wrong");

   COV_ADD_OVF: cover property (exec && cmd.op == op_add ##1 cc_q.v);
   COV_DIV_ZERO: cover property (exec && cmd.op == op_divide && src_q == WORD_RST);
   COV_MUL_BIG: cover property (exec && cmd.op == op_multiply ##1 cc_q.c);
   COV_MOVE_BYTE_OP_REG: cover property (exec && cmd.op == op_move && cmd.byte_op && cmd.dreg);
endmodule
`default_nettype wire

// file: shared/cdoa_pkg.sv
// Purpose: Shared constants and types for the double-operand ALU datapath
// Assumes: 16-bit operands, 4-bit register port address
// Notes:   Command word layout matches cdoa_ctrl_t packing
`default_nettype none
package cdoa_pkg;
   // Bus geometry
   localparam int AW = 4;
   localparam int DW = 16;
   // Register port offsets
   localparam logic [3:0] ADR_CTRL = 4'h0;  // Command, starts execution
   localparam logic [3:0] ADR_SRC  = 4'h1;  // Source / first source operand
   localparam logic [3:0] ADR_DST  = 4'h2;  // Destination / second source
   localparam logic [3:0] ADR_STEP = 4'h3;  // Auto-increment / decrement
   localparam logic [3:0] ADR_CC   = 4'h4;  // Condition codes N Z V C
   localparam logic [3:0] ADR_RES  = 4'h5;  // Result word
   localparam logic [3:0] ADR_STAT = 4'h6;  // Done and write flags
   localparam logic [3:0] ADR_GPR0 = 4'h8;  // General registers 8..F
   // Field positions in the step command
   localparam int STEP_SUB_BIT  = 3;
   localparam int STEP_BYTE_BIT = 4;
   // Special register indexes
   localparam logic [2:0] SP_IDX = 3'h6;
   // Step sizes
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   // Reset values
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [3:0]  CC_RST   = 4'h0;
   // Operation codes
   typedef enum logic [3:0] {
      op_move, op_compare, op_or_set, op_and_clear, op_add,
      op_sub, op_multiply, op_divide, op_xor, op_byte_swap
   } cdoa_op_t;
   // Condition codes
   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } cdoa_cc_t;
   // Command word, low nine bits of write data
   typedef struct packed {
      logic [2:0] rn;       // Named register number
      logic       dreg;     // Destination is a register
      logic       byte_op;  // Byte form
      cdoa_op_t   op;
   } cdoa_ctrl_t;
   // Register port request
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } cdoa_bus_req_t;
endpackage
`default_nettype wire

// file: sim/cdoa_seq_model.sv
// Purpose: Sequencer model that feeds the ALU register port
// Assumes: Requests taken on the rising edge, read data one cycle later
// Notes:   Released write data and read address lines carry inverted values, never stale ones
`default_nettype none
module cdoa_seq_model (
   // Clock
   input  wire logic                    clk,
   // Register port
   output var  cdoa_pkg::cdoa_bus_req_t req,
   input  wire logic [cdoa_pkg::DW-1:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import cdoa_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Quiet port at time zero
   initial req = '0;

   // One write cycle; strobe drops at the edge that takes it
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'h1;
      @(posedge clk);
      req.wr    <= 1'h0;
      req.wdata <= ~d;
   endtask

   // One read cycle; data taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      req.addr <= a;
      req.rd   <= 1'h1;
      @(posedge clk);
      req.rd   <= 1'h0;
      req.addr <= ~a;
      @(negedge clk);
      d = rdata;
   endtask

   // Command word: named register, register flag, byte flag, operation
   task automatic cmd(input cdoa_op_t op, input logic bt, input logic dr, input logic [2:0] n);
      wr(ADR_CTRL, {7'h00, n, dr, bt, op});
   endtask
endmodule
`default_nettype wire

// file: sim/compat_double_operand_alu_test.sv
// Purpose: Self-checking bench for the double-operand ALU datapath
// Assumes: Sequencer model drives every register port request
// Notes:   Expected values are worked out here from the operands and the expected flags
`default_nettype none
module compat_double_operand_alu_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cdoa_pkg::*;

   logic          clk;          // Core clock
   logic          rst_n;        // Synchronous reset, active low
   cdoa_bus_req_t bus_req;      // Register port request
   logic [DW-1:0] rdata_q;      // Read data
   logic [DW-1:0] result_q;     // Result word
   logic          dst_wr_q;     // Destination write pulse
   logic          done_q;       // Command done
   cdoa_cc_t      cc_q;         // Condition codes
   cdoa_cc_t      cc_exp;       // Expected condition codes
   int            miscompares;  // Mismatch counter
   int            cmp_count;    // Comparison counter

   // Operation table: op, {byte, dst register}, {src, dst}
   cdoa_op_t    v_op [16] = '{op_move, op_move, op_move, op_add, op_add, op_sub, op_sub,
      op_compare, op_compare, op_or_set, op_or_set, op_and_clear, op_and_clear, op_xor,
      op_byte_swap, op_move};
   logic [1:0]  v_md [16] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h1,
      2'h2, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1};
   logic [31:0] v_sd [16] = '{32'h8000_0000, 32'h0080_1234, 32'h0080_1234, 32'h0001_7FFF,
      32'h0001_FFFF, 32'h0001_8000, 32'h0001_0000, 32'h8000_0001, 32'h0001_0002,
      32'h00F0_0F00, 32'h0081_AA00, 32'hFFFF_FFFF, 32'h000F_12FF, 32'h5555_AAAA,
      32'h0000_80FF, 32'h0000_1234};

   ////////////////////////////////////////////////////////////////////////
   cdoa_alu u_cdoa_alu (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata_q(rdata_q),
      .result_q(result_q), .dst_wr_q(dst_wr_q), .done_q(done_q), .cc_q(cc_q));
   cdoa_seq_model u_cdoa_seq_model (.clk(clk), .req(bus_req), .rdata(rdata_q));

   // 100 MHz clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Read one register and compare
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string what);
      logic [15:0] d;
      u_cdoa_seq_model.rd(a, d);
      check(d, e, what);
   endtask

   // Reference result: {write flag, n z v c, result}
   function automatic logic [20:0] ref_op(input cdoa_op_t op, input logic bt,
      input logic dr, input logic [15:0] s, input logic [15:0] d, input cdoa_cc_t ci);
      logic [16:0] t;
      logic [15:0] r;
      logic        lo, we, v, c;
      lo = bt;
      we = 1'h1;
      v  = 1'h0;
      c  = ci.c;
      t  = {1'h0, s};
      case (op)
         op_or_set:    t = {1'h0, d | s};
         op_and_clear: t = {1'h0, d & ~s};
         op_xor:       t = {1'h0, d ^ s};
         op_add: begin
            t = {1'h0, d} + {1'h0, s};
            c = t[16];
            v = (s[15] == d[15]) && (t[15] != d[15]);
         end
         op_sub: begin
            t = {1'h0, d} - {1'h0, s};
            c = t[16];
            v = (s[15] != d[15]) && (t[15] == s[15]);
         end
         op_compare: begin
            t  = bt ? {9'h000, s[7:0]} - {9'h000, d[7:0]} : {1'h0, s} - {1'h0, d};
            c  = bt ? t[8] : t[16];
            v  = bt ? (s[7] != d[7]) && (t[7] == d[7]) : (s[15] != d[15]) && (t[15] == d[15]);
            we = 1'h0;
         end
         op_byte_swap: begin
            t  = {1'h0, d[7:0], d[15:8]};
            c  = 1'h0;
            lo = 1'h1;
         end
         default: ;
      endcase
      r = t[15:0];
      // Byte forms keep the high byte, except move into a register
      if (bt && op != op_compare)
         r = (op == op_move && dr) ? {{8{s[7]}}, s[7:0]} : {d[15:8], t[7:0]};
      return {we, lo ? r[7] : r[15], lo ? (r[7:0] == 8'h00) : (r == 16'h0000), v, c, r};
   endfunction

   // One command with operands, checked in the cycle after
   task automatic do_op(input cdoa_op_t op, input logic bt, input logic dr,
      input logic [15:0] s, input logic [15:0] d);
      logic [20:0] e;
      e = ref_op(op, bt, dr, s, d, cc_exp);
      u_cdoa_seq_model.wr(ADR_GPR0 | 4'h2, s);
      u_cdoa_seq_model.wr(ADR_SRC, s);
      u_cdoa_seq_model.wr(ADR_DST, d);
      u_cdoa_seq_model.cmd(op, bt, dr, 3'h2);
      @(negedge clk);
      cc_exp = e[19:16];
      check({12'h000, cc_q}, {12'h000, e[19:16]}, "flags");
      check({15'h0000, dst_wr_q}, {15'h0000, e[20]}, "dst write");
      check({15'h0000, done_q}, 16'h0001, "done");
      if (e[20])
         check(result_q, e[15:0], "result");
      @(negedge clk);
      check({15'h0000, dst_wr_q}, 16'h0000, "dst write pulse");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, unmapped place, flag register write
   task automatic t_bus();
      rd_chk(ADR_CC, 16'h0000, "cc reset");
      rd_chk(ADR_RES, 16'h0000, "result reset");
      rd_chk(4'h7, 16'h0000, "unmapped read");
      u_cdoa_seq_model.wr(4'h7, 16'hFFFF);
      u_cdoa_seq_model.wr(ADR_CC, 16'h000F);
      rd_chk(ADR_CC, 16'h000F, "cc write");
      rd_chk(ADR_GPR0, 16'h0000, "r0 reset");
      cc_exp = 4'hF;
      $display("test bus done");
   endtask

   // Every table row; carry kept or set as each operation asks
   task automatic t_ops();
      for (int i = 0; i < 16; i++) begin
         do_op(v_op[i], v_md[i][1], v_md[i][0], v_sd[i][31:16], v_sd[i][15:0]);
      end
      $display("test ops done");
   endtask

   // Register stepping leaves the fetched source alone
   task automatic t_step();
      u_cdoa_seq_model.wr(ADR_GPR0 | 4'h2, 16'h1000);
      u_cdoa_seq_model.wr(ADR_SRC, 16'h1111);
      u_cdoa_seq_model.wr(ADR_STEP, 16'h0002);
      rd_chk(ADR_STEP, 16'h1000, "step old value");
      rd_chk(ADR_SRC, 16'h1111, "source kept");
      rd_chk(ADR_GPR0 | 4'h2, 16'h1002, "r2 stepped");
      u_cdoa_seq_model.wr(ADR_GPR0 | 4'h6, 16'h0010);
      u_cdoa_seq_model.wr(ADR_STEP, 16'h001E);
      rd_chk(ADR_STEP, 16'h000E, "stack step by two");
      $display("test step done");
   endtask

   // Multiply into pair n, n|1
   task automatic mul_case(input logic [2:0] n, input logic [15:0] a, input logic [15:0] b);
      logic [31:0] p;
      p = $signed(a) * $signed(b);
      u_cdoa_seq_model.wr(ADR_GPR0 | {1'h0, n}, a);
      u_cdoa_seq_model.wr(ADR_SRC, b);
      u_cdoa_seq_model.cmd(op_multiply, 1'h0, 1'h1, n);
      @(negedge clk);
      cc_exp = {p[31], p == 32'h0, 1'h0, p[31:15] != 17'h00000 && p[31:15] != 17'h1FFFF};
      check({12'h000, cc_q}, {12'h000, cc_exp}, "mul flags");
      if (!n[0])
         rd_chk(ADR_GPR0 | {1'h0, n}, p[31:16], "mul high");
      rd_chk(ADR_GPR0 | {1'h0, n | 3'h1}, p[15:0], "mul low");
   endtask

   // Divide pair r2:r3
   task automatic div_case(input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] dv);
      int          dd, q, rm;
      logic [15:0] e2, e3;
      cdoa_cc_t    ce;
      dd = {hi, lo};
      e2 = hi;
      e3 = lo;
      ce = {cc_exp.n, cc_exp.z, 1'h1, 1'h1};
      if (dv != 16'h0000) begin
         q    = dd / $signed(dv);
         rm   = dd % $signed(dv);
         ce   = {q[15], q[15:0] == 16'h0000, 1'h1, 1'h0};
         if (q >= -32768 && q < 32768) begin
            e2 = q[15:0];
            e3 = rm[15:0];
            ce.v = 1'h0;
         end
      end
      u_cdoa_seq_model.wr(ADR_GPR0 | 4'h2, hi);
      u_cdoa_seq_model.wr(ADR_GPR0 | 4'h3, lo);
      u_cdoa_seq_model.wr(ADR_SRC, dv);
      u_cdoa_seq_model.cmd(op_divide, 1'h0, 1'h1, 3'h2);
      @(negedge clk);
      cc_exp = ce;
      check({12'h000, cc_q}, {12'h000, ce}, "div flags");
      rd_chk(ADR_GPR0 | 4'h2, e2, "quotient");
      rd_chk(ADR_GPR0 | 4'h3, e3, "remainder");
   endtask

   // Multiply and divide cases
   task automatic t_muldiv();
      mul_case(3'h2, 16'h0100, 16'h0100);
      mul_case(3'h2, 16'hFFFF, 16'h0002);
      mul_case(3'h3, 16'h0003, 16'h0004);
      div_case(16'h0000, 16'h0007, 16'h0002);
      div_case(16'hFFFF, 16'hFFF9, 16'h0002);
      div_case(16'h0000, 16'h0007, 16'h0000);
      div_case(16'h0001, 16'h0000, 16'h0001);
      $display("test muldiv done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      miscompares = 0;
      cmp_count   = 0;
      cc_exp      = 4'h0;
      rst_n       = 1'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      t_bus();
      t_ops();
      t_step();
      t_muldiv();
      summarize();
   end

   // Watchdog: tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
